// ==== shared/bmfifo_pkg.sv ====
// Package for the bus-matching read side of a two-port FIFO
// Assumes one system clock; port clocks and pins arrive as sampled inputs
package bmfifo_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int          DW          = 36;
  localparam int          LANE        = 9;
  localparam int          WORD_W      = 18;
  localparam int          DEPTH_LOG2  = 11;
  localparam int          ALMOST_EMPTY_OFFSET = 8;
  localparam int          ALMOST_FULL_OFFSET  = 8;
  localparam logic [1:0]  PIECE_LAST_WORD = 2'h1;
  localparam logic [1:0]  PIECE_LAST_BYTE = 2'h3;
  localparam logic [1:0]  PIECE_FIRST     = 2'h0;

  // ----------------------------------------------------------------
  // AXI4-Lite register map
  // ----------------------------------------------------------------
  localparam logic [7:0]  REG_CTRL    = 8'h00;  // Mode bits
  localparam logic [7:0]  REG_STATUS  = 8'h04;  // Flag readback
  localparam logic [7:0]  REG_A_TO_B_MAILBOX   = 8'h08;  // A-to-B mailbox
  localparam logic [7:0]  REG_B_TO_A_MAILBOX   = 8'h0c;  // B-to-A mailbox
  localparam logic [7:0]  REG_RETX    = 8'h10;  // Write starts retransmit
  localparam int          CTRL_WMS    = 0;
  localparam int          CTRL_NWS    = 1;
  localparam int          CTRL_FTM    = 2;
  localparam logic [31:0] CTRL_RESET  = 32'h0000_0000;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // Pin synchroniser length
  localparam int          SYNC_STAGES = 3;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    BMF_IDLE  = 2'b00,
    BMF_FETCH = 2'b01,
    BMF_SHOW  = 2'b11
  } bmf_state_t;

  typedef struct packed {
    logic        wms;  // width_match_select
    logic        nws;  // narrow_width_select
    logic        ftm;  // fall_through_mode
  } bmf_cfg_t;

  typedef struct packed {
    logic        empty_flag_n;
    logic        output_valid;
    logic        full_flag_n;
    logic        input_space_ready;
    logic        almost_empty_n;
    logic        almost_full_n;
    logic        mail_one_flag;
    logic        mail_two_flag;
  } bmf_flags_t;

endpackage

// ==== src/bmfifo_read_side.sv ====
// Read-side bus matching, flags and mailboxes of a 36-bit FIFO
// Assumes Port A and Port B strobes arrive from pins and are resynchronised
`timescale 1ns/100ps

module bmfifo_read_side
  import bmfifo_pkg::*;
#(
  parameter int DEPTH_W = DEPTH_LOG2
) (
  // Clock and reset
  input  wire logic              SYS_CLK,
  input  wire logic              RST_N,
  // Configuration pin
  input  wire logic              BYTE_ORDER_SELECT,
  // Port A (writer) pins
  input  wire logic              PORT_A_WRITE,
  input  wire logic              PORT_A_MAIL_WRITE,
  input  wire logic              PORT_A_MAIL_READ,
  input  wire logic [DW-1:0]     PORT_A_DATA_IN,
  output logic      [DW-1:0]     PORT_A_DATA_OUT,
  // Port B (reader) pins
  input  wire logic              PORT_B_READ,
  input  wire logic              PORT_B_MAIL_WRITE,
  input  wire logic              PORT_B_MAIL_READ,
  input  wire logic [DW-1:0]     PORT_B_DATA_IN,
  output logic      [DW-1:0]     PORT_B_DATA_OUT,
  // Flags
  output logic                   EMPTY_FLAG_N,
  output logic                   OUTPUT_VALID,
  output logic                   FULL_FLAG_N,
  output logic                   INPUT_SPACE_READY,
  output logic                   ALMOST_EMPTY_N,
  output logic                   ALMOST_FULL_N,
  output logic                   MAIL_ONE_FLAG,
  output logic                   MAIL_TWO_FLAG,
  // AXI4-Lite slave
  input  wire logic [7:0]        S_AXI_AWADDR,
  input  wire logic              S_AXI_AWVALID,
  output logic                   S_AXI_AWREADY,
  input  wire logic [31:0]       S_AXI_WDATA,
  input  wire logic [3:0]        S_AXI_WSTRB,
  input  wire logic              S_AXI_WVALID,
  output logic                   S_AXI_WREADY,
  output logic      [1:0]        S_AXI_BRESP,
  output logic                   S_AXI_BVALID,
  input  wire logic              S_AXI_BREADY,
  input  wire logic [7:0]        S_AXI_ARADDR,
  input  wire logic              S_AXI_ARVALID,
  output logic                   S_AXI_ARREADY,
  output logic      [31:0]       S_AXI_RDATA,
  output logic      [1:0]        S_AXI_RRESP,
  output logic                   S_AXI_RVALID,
  input  wire logic              S_AXI_RREADY
);

  localparam int NSTR = 7;
  localparam logic [DEPTH_W:0] FULL_CNT = (DEPTH_W+1)'(1 << DEPTH_W);
  localparam logic [DEPTH_W:0] ALMOST_EMPTY_CNT = (DEPTH_W+1)'(ALMOST_EMPTY_OFFSET);
  localparam logic [DEPTH_W:0] ALMOST_FULL_CNT  = (DEPTH_W+1)'((1 << DEPTH_W) - ALMOST_FULL_OFFSET);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [NSTR-1:0] pin_raw;
  logic [NSTR-1:0] sync1, sync2, sync3, last_level;
  logic [NSTR-1:0] pulse, next_level;
  logic            wr_a, mwr_a, mrd_a, rd_b, mwr_b, mrd_b, bos;

  assign pin_raw = {BYTE_ORDER_SELECT, PORT_A_WRITE, PORT_A_MAIL_WRITE, PORT_A_MAIL_READ,
                    PORT_B_READ, PORT_B_MAIL_WRITE, PORT_B_MAIL_READ};

  // Three stages run through reset so the order pin is settled at release
  always_ff @(posedge SYS_CLK) begin
    sync1 <= pin_raw;
    sync2 <= sync1;
    sync3 <= sync2;
  end

  // Agreed level remembered for edge detection; pins idle low
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      last_level <= '0;
    end else begin
      last_level <= next_level;
    end
  end

  // Agreed level and its rising pulse
  always_comb begin
    for (int i = 0; i < NSTR; i++) begin
      next_level[i] = (sync2[i] == sync3[i]) ? sync3[i] : last_level[i];
      pulse[i]      = next_level[i] & ~last_level[i];
    end
  end
  assign {bos, wr_a, mwr_a, mrd_a, rd_b, mwr_b, mrd_b} =
         {next_level[6], pulse[5:0]};

  // ----------------------------------------------------------------
  // Configuration registers and AXI4-Lite slave
  // ----------------------------------------------------------------
  bmf_cfg_t   cfg, next_cfg;
  logic       big_endian, next_big_endian, rst_seen, next_rst_seen;
  logic       aw_hold, next_aw_hold, w_hold, next_w_hold;
  logic [7:0] aw_addr, next_aw_addr;
  logic [31:0] w_data, next_w_data;
  logic       bvalid, next_bvalid, rvalid, next_rvalid;
  logic [1:0] bresp, next_bresp, rresp, next_rresp;
  logic [31:0] rdata, next_rdata;
  logic       retx_req;
  bmf_flags_t flags;
  logic [DW-1:0] a_to_b_mailbox, next_a_to_b_mailbox, b_to_a_mailbox, next_b_to_a_mailbox;

  // Bus accept, decode and answer
  always_comb begin
    next_cfg        = cfg;
    next_rst_seen   = 1'b1;
    next_big_endian = rst_seen ? big_endian : bos;
    next_aw_hold    = aw_hold;
    next_aw_addr    = aw_addr;
    next_w_hold     = w_hold;
    next_w_data     = w_data;
    next_bvalid     = bvalid & ~S_AXI_BREADY;
    next_bresp      = bresp;
    next_rvalid     = rvalid & ~S_AXI_RREADY;
    next_rresp      = rresp;
    next_rdata      = rdata;
    retx_req        = 1'b0;
    if (S_AXI_AWVALID && !aw_hold) begin
      next_aw_hold = 1'b1;
      next_aw_addr = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && !w_hold) begin
      next_w_hold = 1'b1;
      next_w_data = S_AXI_WDATA;
    end
    if (aw_hold && w_hold && !bvalid) begin
      next_aw_hold = 1'b0;
      next_w_hold  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = RESP_OKAY;
      case (aw_addr)
        REG_CTRL: begin
          next_cfg.wms = w_data[CTRL_WMS];
          next_cfg.nws = w_data[CTRL_NWS];
          next_cfg.ftm = w_data[CTRL_FTM];
        end
        REG_STATUS, REG_A_TO_B_MAILBOX, REG_B_TO_A_MAILBOX: begin
        end
        REG_RETX: begin
          retx_req = 1'b1;
        end
        default: begin
          next_bresp = RESP_SLVERR;
        end
      endcase
    end
    if (S_AXI_ARVALID && !rvalid) begin
      next_rvalid = 1'b1;
      next_rresp  = RESP_OKAY;
      case (S_AXI_ARADDR)
        REG_CTRL:   next_rdata = {29'h0, cfg.ftm, cfg.nws, cfg.wms};  // Fields at bits 2..0
        REG_STATUS: next_rdata = {23'h0, big_endian, flags};
        REG_A_TO_B_MAILBOX:  next_rdata = a_to_b_mailbox[31:0];  // Bus shows the low 32 bits
        REG_B_TO_A_MAILBOX:  next_rdata = b_to_a_mailbox[31:0];
        REG_RETX:   next_rdata = 32'h0;
        default: begin
          next_rdata = 32'h0;
          next_rresp = RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      cfg        <= '{wms: CTRL_RESET[CTRL_WMS], nws: CTRL_RESET[CTRL_NWS],
                      ftm: CTRL_RESET[CTRL_FTM]};
      big_endian <= 1'b0;
      rst_seen   <= 1'b0;
      aw_hold    <= 1'b0;
      aw_addr    <= 8'h00;
      w_hold     <= 1'b0;
      w_data     <= 32'h0;
      bvalid     <= 1'b0;
      bresp      <= 2'h0;
      rvalid     <= 1'b0;
      rresp      <= 2'h0;
      rdata      <= 32'h0;
    end else begin
      cfg        <= next_cfg;
      big_endian <= next_big_endian;
      rst_seen   <= next_rst_seen;
      aw_hold    <= next_aw_hold;
      aw_addr    <= next_aw_addr;
      w_hold     <= next_w_hold;
      w_data     <= next_w_data;
      bvalid     <= next_bvalid;
      bresp      <= next_bresp;
      rvalid     <= next_rvalid;
      rresp      <= next_rresp;
      rdata      <= next_rdata;
    end
  end

  // ----------------------------------------------------------------
  // FIFO memory, pointers and bus matching
  // ----------------------------------------------------------------
  logic [DW-1:0]      mem [0:(1<<DEPTH_W)-1];
  logic [DEPTH_W-1:0] wptr, next_wptr, rptr, next_rptr;
  logic [DEPTH_W:0]   count, next_count;
  logic [DW-1:0]      aux, next_aux, outreg, next_outreg;
  logic [1:0]         piece, next_piece;
  bmf_state_t         state, next_state;
  logic               loaded, next_loaded;
  logic               mf1, next_mf1, mf2, next_mf2;
  logic               do_write, last_piece, fetch;

  // Lane for a piece under the chosen order
  function automatic logic [LANE-1:0] pick_byte(input logic [DW-1:0] w,
                                                input logic [1:0] idx);
    pick_byte = w[LANE*(3 - int'(idx)) +: LANE];
  endfunction

  // Mask mail to the lanes of the current width
  function automatic logic [DW-1:0] lane_mask(input logic [DW-1:0] d, input bmf_cfg_t c);
    lane_mask = !c.wms ? d : (c.nws ? {27'h0, d[LANE-1:0]} : {18'h0, d[WORD_W-1:0]});
  endfunction

  assign do_write   = wr_a && (count != FULL_CNT);
  assign last_piece = !cfg.wms ||
                      (cfg.nws ? piece == PIECE_LAST_BYTE : piece == PIECE_LAST_WORD);

  // Next state for pointers, pieces and output register
  always_comb begin
    next_state  = state;
    next_wptr   = do_write ? wptr + 1'b1 : wptr;
    next_rptr   = rptr;
    next_aux    = aux;
    next_outreg = outreg;
    next_piece  = piece;
    next_loaded = loaded;
    fetch       = 1'b0;
    case (state)
      BMF_IDLE: begin
        // Fetch only when nothing is held or the last piece has gone out
        if (count != '0 && ((!loaded && (cfg.ftm || rd_b)) || (rd_b && last_piece))) begin
          next_state = BMF_FETCH;
        end else if (rd_b && loaded) begin
          // Narrow read steps through the auxiliary copy; last piece empties
          if (last_piece) begin
            next_loaded = 1'b0;
          end else begin
            next_piece = piece + 1'b1;
          end
        end
      end
      BMF_FETCH: begin
        fetch       = 1'b1;
        next_aux    = mem[rptr];
        next_rptr   = rptr + 1'b1;
        next_piece  = PIECE_FIRST;
        next_state  = BMF_SHOW;
      end
      BMF_SHOW: begin
        next_loaded = 1'b1;
        next_state  = BMF_IDLE;
      end
      default: next_state = BMF_IDLE;
    endcase
    if (retx_req) begin
      next_rptr   = '0;
      next_loaded = 1'b0;
      next_piece  = PIECE_FIRST;
      next_state  = BMF_IDLE;
    end
    // Present selected piece; byte order from the reset-time latch
    if (!cfg.wms) next_outreg = aux;
    else if (!cfg.nws) next_outreg = {18'h0, (big_endian ^ next_piece[0]) ?
                                      aux[DW-1:WORD_W] : aux[WORD_W-1:0]};
    else next_outreg = {27'h0, pick_byte(aux, big_endian ? next_piece : ~next_piece)};
    next_count = count + (do_write ? 1'b1 : 1'b0) - (fetch ? 1'b1 : 1'b0);
    // Rewind keeps a write that lands in the same cycle
    if (retx_req) next_count = (DEPTH_W+1)'(next_wptr);
  end

  // Mailboxes: writes gated by flag, reads leave data intact
  always_comb begin
    next_a_to_b_mailbox = a_to_b_mailbox;
    next_b_to_a_mailbox = b_to_a_mailbox;
    next_mf1   = mf1;
    next_mf2   = mf2;
    if (mrd_b) next_mf1 = 1'b1;
    if (mrd_a) next_mf2 = 1'b1;
    if (mwr_a && mf1) begin
      next_a_to_b_mailbox = lane_mask(PORT_A_DATA_IN, cfg);
      next_mf1   = 1'b0;
    end
    if (mwr_b && mf2) begin
      next_b_to_a_mailbox = lane_mask(PORT_B_DATA_IN, cfg);
      next_mf2   = 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (do_write) mem[wptr] <= PORT_A_DATA_IN;
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      state  <= BMF_IDLE;
      wptr   <= '0;
      rptr   <= '0;
      count  <= '0;
      aux    <= '0;
      outreg <= '0;
      piece  <= PIECE_FIRST;
      loaded <= 1'b0;
      a_to_b_mailbox  <= '0;
      b_to_a_mailbox  <= '0;
      mf1    <= 1'b1;
      mf2    <= 1'b1;
    end else begin
      state  <= next_state;
      wptr   <= next_wptr;
      rptr   <= next_rptr;
      count  <= next_count;
      aux    <= next_aux;
      outreg <= next_outreg;
      piece  <= next_piece;
      loaded <= next_loaded;
      a_to_b_mailbox  <= next_a_to_b_mailbox;
      b_to_a_mailbox  <= next_b_to_a_mailbox;
      mf1    <= next_mf1;
      mf2    <= next_mf2;
    end
  end

  // ----------------------------------------------------------------
  // Flags and registered outputs
  // ----------------------------------------------------------------
  always_comb begin
    flags.output_valid      = cfg.ftm & loaded;
    flags.empty_flag_n      = !cfg.ftm & ((count != '0) | (loaded & ~last_piece));
    flags.full_flag_n       = !cfg.ftm & (count != FULL_CNT);
    flags.input_space_ready = cfg.ftm & (count != FULL_CNT);
    flags.almost_empty_n    = count > ALMOST_EMPTY_CNT;
    flags.almost_full_n     = count < ALMOST_FULL_CNT;
    flags.mail_one_flag     = mf1;
    flags.mail_two_flag     = mf2;
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      PORT_A_DATA_OUT <= '0;
      PORT_B_DATA_OUT <= '0;
      {EMPTY_FLAG_N, OUTPUT_VALID, FULL_FLAG_N, INPUT_SPACE_READY} <= 4'h0;
      {ALMOST_EMPTY_N, ALMOST_FULL_N, MAIL_ONE_FLAG, MAIL_TWO_FLAG} <= 4'h3;
    end else begin
      PORT_A_DATA_OUT   <= b_to_a_mailbox;
      PORT_B_DATA_OUT   <= next_level[0] ? a_to_b_mailbox : outreg;  // Synchronised mail-read level
      EMPTY_FLAG_N      <= flags.empty_flag_n;
      OUTPUT_VALID      <= flags.output_valid;
      FULL_FLAG_N       <= flags.full_flag_n;
      INPUT_SPACE_READY <= flags.input_space_ready;
      ALMOST_EMPTY_N    <= flags.almost_empty_n;
      ALMOST_FULL_N     <= flags.almost_full_n;
      MAIL_ONE_FLAG     <= flags.mail_one_flag;
      MAIL_TWO_FLAG     <= flags.mail_two_flag;
    end
  end
  assign {S_AXI_AWREADY, S_AXI_WREADY} = {~aw_hold, ~w_hold};
  assign {S_AXI_BVALID, S_AXI_BRESP, S_AXI_RVALID, S_AXI_RRESP, S_AXI_RDATA} =
         {bvalid, bresp, rvalid, rresp, rdata};
  assign S_AXI_ARREADY = ~rvalid;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_MAIL_LOCK: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    !mf1 && !mrd_b |=> $stable(a_to_b_mailbox)) else $error("mailbox changed while flag low");
  AST_MAIL_KEEP: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    mrd_b && !mwr_a |=> $stable(a_to_b_mailbox)) else $error("mailbox read altered data");
  AST_FETCH_LAST: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    state == BMF_FETCH && !retx_req |-> !loaded || last_piece) else $error("fetch before last piece");
  AST_RETX: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    retx_req |=> rptr == '0) else $error("retransmit did not rewind");
  AST_ORDER: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    rst_seen |=> $stable(big_endian)) else $error("byte order changed after reset");
  AST_FALL: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    state == BMF_FETCH && cfg.ftm && !retx_req |-> ##3 OUTPUT_VALID) else $error("fall-through late");
  AST_LONG: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    !cfg.wms && $past(!cfg.wms) |-> outreg == $past(aux)) else $error("long word lanes");
  AST_EMPTY: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    !cfg.ftm && loaded && !last_piece |=> EMPTY_FLAG_N) else $error("empty flag dropped early");

endmodule

// ==== testbench/bmfifo_writer.sv ====
// Port A writer model: one FIFO or mailbox write per request
// Assumes the bench waits for busy to fall before its next request
`timescale 1ns/100ps
module bmfifo_writer (
  // Clock
  input  wire logic        clk,
  // Requests from the bench
  input  wire logic        go_fifo,
  input  wire logic        go_mail,
  input  wire logic [35:0] word,
  output logic             busy,
  // Port A pins
  output logic             a_write,
  output logic             a_mail_write,
  output logic [35:0]      a_data
);
  // Hold data across the pin synchroniser, then show its inverse
  initial begin
    busy = 1'b0;
    a_write = 1'b0;
    a_mail_write = 1'b0;
    a_data = 36'h0;
    forever begin
      @(posedge clk);
      if (go_fifo || go_mail) begin
        busy         <= 1'b1;
        a_data       <= word;
        a_write      <= go_fifo;
        a_mail_write <= go_mail;
        repeat (6) @(posedge clk);
        a_write      <= 1'b0;
        a_mail_write <= 1'b0;
        repeat (5) @(posedge clk);
        a_data       <= ~word;
        busy         <= 1'b0;
      end
    end
  end
endmodule

// ==== testbench/tb_bus_matching_fifo_read_flags.sv ====
// Bench for the read side: bus sizing, flags, mailboxes, retransmit, bus
// Assumes the package and the Port A writer model are compiled first
`timescale 1ns/100ps
module tb_bus_matching_fifo_read_flags;
  import bmfifo_pkg::*;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic          sys_clk = 1'b0, rst_n = 1'b0, bos = 1'b1;
  logic [3:0]    pins = 4'h0;
  logic [DW-1:0] b_in = 36'h0, word = 36'h0, snap, w0, w1, m1, want, a_in, a_out, b_out;
  logic          go_f = 1'b0, go_m = 1'b0, busy, a_wp, a_mp;
  logic [7:0]    f;  // Empty, valid, full, space, almost empty/full, mail one/two
  logic [7:0]    awaddr = 8'h00, araddr = 8'h00;
  logic [31:0]   wdata = 32'h0, rdata, rd;
  logic          awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic          awready, wready, bvalid, arready, rvalid;
  logic [1:0]    bresp, rresp, resp;
  int            error_cnt = 0, tests_run = 0;

  always #50 sys_clk = ~sys_clk;

  bmfifo_writer i_writer (.clk(sys_clk), .go_fifo(go_f), .go_mail(go_m), .word(word),
    .busy(busy), .a_write(a_wp), .a_mail_write(a_mp), .a_data(a_in));

  bmfifo_read_side #(.DEPTH_W(4)) i_dut (.SYS_CLK(sys_clk), .RST_N(rst_n),
    .BYTE_ORDER_SELECT(bos), .PORT_A_WRITE(a_wp), .PORT_A_MAIL_WRITE(a_mp),
    .PORT_A_MAIL_READ(pins[3]), .PORT_A_DATA_IN(a_in), .PORT_A_DATA_OUT(a_out),
    .PORT_B_READ(pins[0]), .PORT_B_MAIL_WRITE(pins[1]), .PORT_B_MAIL_READ(pins[2]),
    .PORT_B_DATA_IN(b_in), .PORT_B_DATA_OUT(b_out), .EMPTY_FLAG_N(f[7]),
    .OUTPUT_VALID(f[6]), .FULL_FLAG_N(f[5]), .INPUT_SPACE_READY(f[4]),
    .ALMOST_EMPTY_N(f[3]), .ALMOST_FULL_N(f[2]), .MAIL_ONE_FLAG(f[1]), .MAIL_TWO_FLAG(f[0]),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));

  // ----------------------------------------------------------------
  // Expectations, comparisons and verdict
  // ----------------------------------------------------------------
  // Piece k of long word w for mode m (0 long, 1 word, 2 byte)
  function automatic logic [DW-1:0] piece(logic [DW-1:0] w, int m, logic be, int k);
    if (m == 0) return w;
    if (m == 1) return {18'h0, (be ^ (k == 1)) ? w[35:18] : w[17:0]};
    return {27'h0, be ? w[35-9*k -: 9] : w[9*k +: 9]};
  endfunction
  function automatic logic [DW-1:0] lanes(int m);
    return (m == 0) ? 36'hf_ffff_ffff : (m == 1) ? 36'h0_0003_ffff : 36'h0_0000_01ff;
  endfunction
  task automatic fail(input string s);
    error_cnt++;
    $display("CHECK FAILED at %0t: %s", $time, s);
  endtask
  task automatic print_verdict();
    if (error_cnt == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic tmo();
    fail("wait timed out");
    print_verdict();
  endtask
  task automatic chk_data(input logic [DW-1:0] g, e, mk);
    tests_run++;
    if ((g & mk) !== (e & mk)) fail("data mismatch");
  endtask
  task automatic chk_bit(input logic g, e);
    tests_run++;
    if (g !== e) fail("flag mismatch");
  endtask
  task automatic chk_resp(input logic [1:0] g, e);
    tests_run++;
    if (g !== e) fail("bus response mismatch");
  endtask

  // ----------------------------------------------------------------
  // Drivers
  // ----------------------------------------------------------------
  task automatic rst(input logic be);
    @(posedge sys_clk);
    rst_n <= 1'b0;
    bos   <= be;
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge sys_clk);
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge sys_clk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (n = 0; n < 50 && !bvalid; n++) begin
      @(posedge sys_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end
    r = bresp;
    bready <= 1'b0;
    if (n == 50) tmo();
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge sys_clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (n = 0; n < 50 && !rvalid; n++) begin
      @(posedge sys_clk);
      if (arready) arvalid <= 1'b0;
    end
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    if (n == 50) tmo();
  endtask
  // Port A write through the writer model, mailbox when m is high
  task automatic a_wr(input logic [DW-1:0] w, input logic m);
    int n;
    @(posedge sys_clk);
    word <= w;
    go_f <= !m;
    go_m <= m;
    @(posedge sys_clk);
    go_f <= 1'b0;
    go_m <= 1'b0;
    for (n = 0; n < 30 && (n < 2 || busy); n++) @(posedge sys_clk);
    if (busy) tmo();
  endtask
  // Pin pulse: 0 read, 1 mail write, 2 mail read, 3 Port A mail read
  task automatic pin(input int s);
    @(posedge sys_clk);
    pins[s] <= 1'b1;
    repeat (10) @(posedge sys_clk);
    snap = b_out;
    pins[s] <= 1'b0;
    repeat (6) @(posedge sys_clk);
  endtask
  task automatic wait_hi(input int i);
    int n;
    for (n = 0; n < 80 && f[i] !== 1'b1; n++) @(posedge sys_clk);
    if (n == 80) tmo();
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    int c, m, p, i, k, np;
    logic be;
    void'($urandom(30));
    // Every size and byte order: two words, retransmit, both mailboxes
    for (c = 0; c < 5; c++) begin
      m  = (c + 1) / 2;
      be = c[0] | (c == 0);
      np = 1 << m;
      rst(be);
      chk_bit(f[7], 1'b0);
      axi_rd(REG_CTRL, rd, resp);
      chk_data({4'h0, rd}, {4'h0, CTRL_RESET}, 36'hf_ffff_ffff);
      axi_wr(REG_CTRL, {30'h0, m == 2, m != 0}, resp);
      chk_resp(resp, RESP_OKAY);
      w0 = DW'({$urandom, $urandom});
      w1 = DW'({$urandom, $urandom});
      a_wr(w0, 1'b0);
      a_wr(w1, 1'b0);
      chk_bit(f[7], 1'b1);
      for (p = 0; p < 2; p++) begin
        for (i = 0; i < 2; i++) begin
          for (k = 0; k < np; k++) begin
            pin(0);
            want = piece(i ? w1 : w0, m, be, k);
            chk_data(snap, want, lanes(m));
            chk_bit(f[7], !(i == 1 && k == np - 1));
          end
        end
        if (p == 0) axi_wr(REG_RETX, 32'h0, resp);
        if (p == 0) wait_hi(7);
      end
      m1 = DW'({$urandom, $urandom});
      a_wr(m1, 1'b1);
      chk_bit(f[1], 1'b0);
      a_wr(~m1, 1'b1);
      for (k = 0; k < 2; k++) begin
        pin(2);
        chk_data(snap, m1, lanes(m));
        chk_bit(f[1], 1'b1);
      end
      b_in <= ~m1;
      pin(1);
      b_in <= m1;
      chk_bit(f[0], 1'b0);
      pin(3);
      chk_data(a_out, ~m1, lanes(m));
      chk_bit(f[0], 1'b1);
    end
    // Fall-through: first word shows by itself, its read empties
    rst(1'b1);
    axi_wr(REG_CTRL, 32'h4, resp);
    a_wr(w0, 1'b0);
    wait_hi(6);
    chk_data(b_out, w0, lanes(0));
    chk_bit(f[4], 1'b1);
    pin(0);
    chk_bit(f[6], 1'b0);
    // Standard mode filled to the depth, then one freeing read
    rst(1'b1);
    axi_wr(REG_CTRL, 32'h0, resp);
    for (i = 0; i < 16; i++) a_wr(DW'(i + 1), 1'b0);
    chk_bit(f[5], 1'b0);
    chk_bit(f[2], 1'b0);
    chk_bit(f[3], 1'b1);
    pin(0);
    chk_data(snap, 36'h1, lanes(0));
    wait_hi(5);
    // Unmapped register
    axi_rd(8'h40, rd, resp);
    chk_resp(resp, RESP_SLVERR);
    chk_data({4'h0, rd}, 36'h0, 36'hf_ffff_ffff);
    print_verdict();
  end
endmodule
